// ---- dv/tapc_host.sv ----
// Host model: the microcontroller side of the bank's register strobe port.
// Assumes the bank answers a read with a one-cycle valid pulse after the taking edge.
module tapc_host (
  input  wire logic        clk,
  output logic      [7:0]  reg_addr,
  output logic      [23:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [23:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------------
  // Idle lines before the first access
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 24'h00_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One write, then the bus lines show the inverse so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // One read; results are taken as stored, no host arithmetic on them
  task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic ok);
    ok = 1'b0;
    d  = 24'h00_0000;
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask

  // Write, then read the same register at the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [23:0] d, output logic [23:0] q);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    @(negedge clk);
    reg_rd    = 1'b0;
    q = (reg_rvalid === 1'b1) ? reg_rdata : 24'hxx_xxxx;
  endtask
endmodule

// ---- dv/tapc_regs_tb.sv ----
// Self-checking bench of the ambient phase correction bank and its steering.
// Assumes tapc_pkg is compiled first and the host model drives the register port.
module tapc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tapc_pkg::*;

  logic        clk, resetn, reg_wr, reg_rd, illum_on, ok, reg_rvalid, unwrapped_phase_output_en;
  logic        ch2_reroute_to_ch0, ch1_reroute_to_ch0, scale_code_invalid;
  logic [7:0]  reg_addr, ambient_segment_coeff_first, ambient_segment_coeff_second, ambient_segment_coeff_third;
  logic [23:0] reg_wdata, reg_rdata, rd_word, w;
  tapc_chan_t  chan_sel;
  logic [15:0] phase_normal, phase_unwrapped, phase_out, ch2_high_quartic_coeff;
  logic [9:0]  ambient_knee_first, ambient_knee_second, ambient_knee_third;
  logic [2:0]  ambient_correction_scaling, ch2_high_current_scale, ch2_low_current_scale, emitter_drive_en;
  logic [1:0]  ch0_ambient_input_select, ch1_ambient_input_select, ch2_ambient_input_select, ambient_input_sel, s;
  int          n_fail, n_tests;
  logic [7:0]  addr_t [5] = '{8'hb2, 8'hb4, 8'hb5, 8'hb8, 8'hb9};
  logic [23:0] rst_t  [5] = '{24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h07_fdff, 24'h00_01ff};
  logic [23:0] mask_t [5] = '{24'h00_ffff, 24'hff_ffff, 24'h00_0007, 24'h1f_ffff, 24'hff_ffff};

  tapc_regs u_tapc_regs (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .chan_sel, .illum_on, .phase_normal, .phase_unwrapped, .ch2_high_quartic_coeff, .ambient_segment_coeff_first,
    .ambient_segment_coeff_second, .ambient_segment_coeff_third, .ambient_correction_scaling,
    .unwrapped_phase_output_en, .ambient_knee_first, .ambient_knee_second, .ambient_knee_third,
    .ch2_high_current_scale, .ch2_low_current_scale, .ch0_ambient_input_select, .ch1_ambient_input_select,
    .ch2_ambient_input_select, .ch2_reroute_to_ch0, .ch1_reroute_to_ch0, .scale_code_invalid, .phase_out,
    .ambient_input_sel, .emitter_drive_en);

  tapc_host u_tapc_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read one register and compare; a missing answer ends the run
  task automatic rchk(input logic [7:0] a, input logic [23:0] exp, input string what);
    u_tapc_host.rd(a, rd_word, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen no answer", what, exp);
      stop_test();
    end else begin
      chk(what, rd_word, exp);
    end
  endtask

  // Present one channel for a cycle and check the registered steering outputs
  task automatic steer(input logic [1:0] ch, input logic on, input logic [1:0] sel, input logic [2:0] drv,
                       input logic en);
    @(negedge clk);
    chan_sel        = tapc_chan_t'(ch);
    illum_on        = on;
    phase_normal    = phase_normal + 16'h0101;
    phase_unwrapped = phase_unwrapped - 16'h0303;
    @(negedge clk);
    chk("ambient input", ambient_input_sel, sel);
    chk("emitter drive", emitter_drive_en, drv);
    chk("phase out", phase_out, en ? phase_unwrapped : phase_normal);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_tests = 0;
    resetn = 1'b0;
    chan_sel = TAPC_CH_NONE;
    illum_on = 1'b0;
    phase_normal = 16'h1234;
    phase_unwrapped = 16'hfedc;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    // Reset words, all-ones writes with reserved bits dropped, then clear
    for (int i = 0; i < 5; i++) begin
      rchk(addr_t[i], rst_t[i], "reset word");
      u_tapc_host.wr(addr_t[i], 24'hff_ffff);
      rchk(addr_t[i], mask_t[i], "masked word");
      if (i == 4) chk("bad code flag", scale_code_invalid, 1'b1);
      u_tapc_host.wr(addr_t[i], 24'h00_0000);
      rchk(addr_t[i], 24'h00_0000, "cleared word");
    end
    // Field patterns
    u_tapc_host.wr(8'hb2, 24'h00_cdef);
    chk("quartic", ch2_high_quartic_coeff, 16'hcdef);
    u_tapc_host.wr(8'hb4, 24'h11_2233);
    chk("segments", {ambient_segment_coeff_third, ambient_segment_coeff_second,
                     ambient_segment_coeff_first}, 24'h11_2233);
    u_tapc_host.wr(8'hb5, 24'h00_0005);
    chk("scaling", ambient_correction_scaling, 3'h5);
    u_tapc_host.wr(8'hb8, {3'b000, 1'b1, 10'h15a, 10'h0a5});
    chk("knees", {unwrapped_phase_output_en, ambient_knee_second, ambient_knee_first},
        {1'b1, 10'h15a, 10'h0a5});
    u_tapc_host.wr_rd(8'hb2, 24'h00_cdef, rd_word);
    chk("quartic back to back", rd_word, 24'h00_cdef);
    // Every legal scale and select code, both reroute settings, every channel
    for (int c = 0; c < 4; c++) begin
      s = c[1:0];
      w = {1'b0, s, 1'b0, ~s, s, ~s, s, s[0], s[1], 10'h2a5};
      u_tapc_host.wr(8'hb9, w);
      rchk(8'hb9, w, "drive word");
      chk("scale high", ch2_high_current_scale, {1'b0, s});
      chk("scale low", ch2_low_current_scale, {1'b0, ~s});
      chk("code flag", scale_code_invalid, 1'b0);
      chk("selects", {ch2_ambient_input_select, ch1_ambient_input_select, ch0_ambient_input_select},
          {s, ~s, s});
      chk("reroutes", {ch2_reroute_to_ch0, ch1_reroute_to_ch0}, {s[0], s[1]});
      chk("knee third", ambient_knee_third, 10'h2a5);
      steer(2'd0, 1'b1, s, 3'b001, 1'b1);
      steer(2'd1, 1'b1, ~s, s[1] ? 3'b001 : 3'b010, 1'b1);
      steer(2'd2, 1'b1, s, s[0] ? 3'b001 : 3'b100, 1'b1);
      steer(2'd3, 1'b1, 2'b00, 3'b000, 1'b1);
      steer(2'd2, 1'b0, s, 3'b000, 1'b1);
    end
    // Normal phase once the enable is cleared
    u_tapc_host.wr(8'hb8, {3'b000, 1'b0, 10'h15a, 10'h0a5});
    steer(2'd0, 1'b1, 2'b11, 3'b001, 1'b0);
    // Unmapped write is ignored, unmapped read answers zero
    u_tapc_host.wr(8'hb3, 24'h55_5555);
    rchk(8'hb3, 24'h00_0000, "unmapped");
    rchk(8'hb2, 24'h00_cdef, "quartic kept");
    // Second reset in mid-run
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    rchk(8'hb9, 24'h00_01ff, "drive after reset");
    rchk(8'hb8, 24'h07_fdff, "knees after reset");
    stop_test();
  end
endmodule

// ---- hw/tapc_regs.sv ----
// Ambient phase correction register bank of a time-of-flight front end, with channel steering.
// Assumes the serial interface engine presents one-cycle read and write strobes on clk.
`include "tapc_params.svh"

module tapc_regs
  import tapc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [23:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire tapc_chan_t  chan_sel,
  input  wire logic        illum_on,
  input  wire logic [15:0] phase_normal,
  input  wire logic [15:0] phase_unwrapped,
  output logic      [15:0] ch2_high_quartic_coeff,
  output logic      [7:0]  ambient_segment_coeff_first,
  output logic      [7:0]  ambient_segment_coeff_second,
  output logic      [7:0]  ambient_segment_coeff_third,
  output logic      [2:0]  ambient_correction_scaling,
  output logic             unwrapped_phase_output_en,
  output logic      [9:0]  ambient_knee_first,
  output logic      [9:0]  ambient_knee_second,
  output logic      [9:0]  ambient_knee_third,
  output logic      [2:0]  ch2_high_current_scale,
  output logic      [2:0]  ch2_low_current_scale,
  output logic      [1:0]  ch0_ambient_input_select,
  output logic      [1:0]  ch1_ambient_input_select,
  output logic      [1:0]  ch2_ambient_input_select,
  output logic             ch2_reroute_to_ch0,
  output logic             ch1_reroute_to_ch0,
  output logic             scale_code_invalid,
  output logic      [15:0] phase_out,
  output logic      [1:0]  ambient_input_sel,
  output logic      [2:0]  emitter_drive_en
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  tapc_regs_t st_r;
  tapc_regs_t st_nxt;

  // Address decode of mapped registers
  logic addr_mapped;

  always_comb begin
    addr_mapped = (reg_addr == `TAPC_ADDR_QUARTIC)  ||
                  (reg_addr == `TAPC_ADDR_SEGCOEFF) ||
                  (reg_addr == `TAPC_ADDR_SCALING)  ||
                  (reg_addr == `TAPC_ADDR_KNEE_LOW) ||
                  (reg_addr == `TAPC_ADDR_DRIVE);
  end

  // ----------------------------------------------------------------------------
  // Register write, read and flag update
  // ----------------------------------------------------------------------------
  // Writes store only writable bits, so reserved bits always read back zero.
  // A read in the same cycle as a write to the same register returns the old word.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `TAPC_ADDR_QUARTIC: begin
          st_nxt.quartic = reg_wdata & `TAPC_MASK_QUARTIC;
        end
        `TAPC_ADDR_SEGCOEFF: begin
          st_nxt.segcoeff = reg_wdata & `TAPC_MASK_SEGCOEFF;
        end
        `TAPC_ADDR_SCALING: begin
          st_nxt.scaling = reg_wdata & `TAPC_MASK_SCALING;
        end
        `TAPC_ADDR_KNEE_LOW: begin
          st_nxt.knee_low = reg_wdata & `TAPC_MASK_KNEE_LOW;
        end
        `TAPC_ADDR_DRIVE: begin
          st_nxt.drive = reg_wdata & `TAPC_MASK_DRIVE;
        end
        default: begin
          st_nxt.quartic = st_r.quartic;  // Unmapped write ignored
        end
      endcase
    end
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      case (reg_addr)
        `TAPC_ADDR_QUARTIC:  st_nxt.rdata = st_r.quartic;
        `TAPC_ADDR_SEGCOEFF: st_nxt.rdata = st_r.segcoeff;
        `TAPC_ADDR_SCALING:  st_nxt.rdata = st_r.scaling;
        `TAPC_ADDR_KNEE_LOW: st_nxt.rdata = st_r.knee_low;
        `TAPC_ADDR_DRIVE:    st_nxt.rdata = st_r.drive;
        default:             st_nxt.rdata = 24'h00_0000;
      endcase
    end
    // Flags a scale code outside the four legal current steps
    st_nxt.scale_bad = (st_nxt.drive[`TAPC_SCALE_H_MSB:`TAPC_SCALE_H_LSB] > `TAPC_SCALE_MAX) ||
                       (st_nxt.drive[`TAPC_SCALE_L_MSB:`TAPC_SCALE_L_LSB] > `TAPC_SCALE_MAX);
  end

  // State register with documented reset values
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r.quartic   <= `TAPC_RST_QUARTIC;
      st_r.segcoeff  <= `TAPC_RST_SEGCOEFF;
      st_r.scaling   <= `TAPC_RST_SCALING;
      st_r.knee_low  <= `TAPC_RST_KNEE_LOW;
      st_r.drive     <= `TAPC_RST_DRIVE;
      st_r.rdata     <= 24'h00_0000;
      st_r.rvalid    <= 1'b0;
      st_r.scale_bad <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------------------
  // Each field is a slice of a stored word
  assign reg_rdata                    = st_r.rdata;
  assign reg_rvalid                   = st_r.rvalid;
  assign ch2_high_quartic_coeff       = st_r.quartic[`TAPC_QUARTIC_MSB:`TAPC_QUARTIC_LSB];
  assign ambient_segment_coeff_first  = st_r.segcoeff[`TAPC_SEG1_MSB:`TAPC_SEG1_LSB];
  assign ambient_segment_coeff_second = st_r.segcoeff[`TAPC_SEG2_MSB:`TAPC_SEG2_LSB];
  assign ambient_segment_coeff_third  = st_r.segcoeff[`TAPC_SEG3_MSB:`TAPC_SEG3_LSB];
  assign ambient_correction_scaling   = st_r.scaling[`TAPC_SCALING_MSB:`TAPC_SCALING_LSB];
  assign unwrapped_phase_output_en    = st_r.knee_low[`TAPC_UNWRAP_BIT];
  assign ambient_knee_first           = st_r.knee_low[`TAPC_KNEE1_MSB:`TAPC_KNEE1_LSB];
  assign ambient_knee_second          = st_r.knee_low[`TAPC_KNEE2_MSB:`TAPC_KNEE2_LSB];
  assign ambient_knee_third           = st_r.drive[`TAPC_KNEE3_MSB:`TAPC_KNEE3_LSB];
  assign ch2_high_current_scale       = st_r.drive[`TAPC_SCALE_H_MSB:`TAPC_SCALE_H_LSB];
  assign ch2_low_current_scale        = st_r.drive[`TAPC_SCALE_L_MSB:`TAPC_SCALE_L_LSB];
  assign ch2_ambient_input_select     = st_r.drive[`TAPC_AMB2_MSB:`TAPC_AMB2_LSB];
  assign ch1_ambient_input_select     = st_r.drive[`TAPC_AMB1_MSB:`TAPC_AMB1_LSB];
  assign ch0_ambient_input_select     = st_r.drive[`TAPC_AMB0_MSB:`TAPC_AMB0_LSB];
  assign ch2_reroute_to_ch0           = st_r.drive[`TAPC_RR2_BIT];
  assign ch1_reroute_to_ch0           = st_r.drive[`TAPC_RR1_BIT];
  assign scale_code_invalid           = st_r.scale_bad;

  // ----------------------------------------------------------------------------
  // Channel steering
  // ----------------------------------------------------------------------------
  // Applies the stored selects to the live channel and phase inputs
  tapc_steer u_steer (
    .clk               (clk),
    .resetn            (resetn),
    .chan_sel          (chan_sel),
    .illum_on          (illum_on),
    .phase_normal      (phase_normal),
    .phase_unwrapped   (phase_unwrapped),
    .unwrap_en         (unwrapped_phase_output_en),
    .amb_sel_ch0       (ch0_ambient_input_select),
    .amb_sel_ch1       (ch1_ambient_input_select),
    .amb_sel_ch2       (ch2_ambient_input_select),
    .reroute_ch1       (ch1_reroute_to_ch0),
    .reroute_ch2       (ch2_reroute_to_ch0),
    .phase_out         (phase_out),
    .ambient_input_sel (ambient_input_sel),
    .emitter_drive_en  (emitter_drive_en)
  );

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!resetn)
    ((st_r.quartic & ~`TAPC_MASK_QUARTIC) == 24'h00_0000) &&
    ((st_r.scaling & ~`TAPC_MASK_SCALING) == 24'h00_0000) &&
    ((st_r.knee_low & ~`TAPC_MASK_KNEE_LOW) == 24'h00_0000)
  ) else $error("reserved bit holds a one");

  unmapped_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_rd && !addr_mapped |=> reg_rvalid && (reg_rdata == 24'h00_0000)
  ) else $error("unmapped read did not return zero");

  quartic_write_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_QUARTIC)
      |=> (st_r.quartic == ($past(reg_wdata) & `TAPC_MASK_QUARTIC))
  ) else $error("quartic coefficient not stored");

  quartic_readback_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_QUARTIC) ##1 reg_rd && !reg_wr && (reg_addr == `TAPC_ADDR_QUARTIC)
      |=> (reg_rdata == ($past(reg_wdata, 2) & `TAPC_MASK_QUARTIC))
  ) else $error("quartic coefficient readback wrong");

  segment_write_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_SEGCOEFF)
      |=> ({ambient_segment_coeff_third, ambient_segment_coeff_second, ambient_segment_coeff_first}
           == $past(reg_wdata))
  ) else $error("segment coefficients not stored in byte order");

  scaling_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !(reg_wr && (reg_addr == `TAPC_ADDR_SCALING)) |=> $stable(ambient_correction_scaling)
  ) else $error("scaling factor changed without a write");

  scaling_write_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_SCALING)
      |=> (st_r.scaling == ($past(reg_wdata) & `TAPC_MASK_SCALING))
  ) else $error("scaling factor not stored");

  knee_write_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_KNEE_LOW)
      |=> ({unwrapped_phase_output_en, ambient_knee_second, ambient_knee_first}
           == ($past(reg_wdata) & `TAPC_MASK_KNEE_LOW))
  ) else $error("knee points or unwrap enable not stored");

  high_scale_bad_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_DRIVE) && (reg_wdata[23:21] > 3'h3) |=> scale_code_invalid
  ) else $error("illegal high current scale not flagged");

  low_scale_bad_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_DRIVE) && (reg_wdata[20:18] > 3'h3) |=> scale_code_invalid
  ) else $error("illegal low current scale not flagged");

  scale_good_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_DRIVE) && (reg_wdata[23:21] <= 3'h3) && (reg_wdata[20:18] <= 3'h3)
      |=> !scale_code_invalid
  ) else $error("legal current scale flagged as invalid");

  quartic_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `TAPC_ADDR_QUARTIC)
      |=> (reg_rdata == {8'h00, $past(ch2_high_quartic_coeff)})
  ) else $error("quartic read wrong");

  segment_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `TAPC_ADDR_SEGCOEFF)
      |=> (reg_rdata == {$past(ambient_segment_coeff_third), $past(ambient_segment_coeff_second),
                         $past(ambient_segment_coeff_first)})
  ) else $error("segment read wrong");

  scaling_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `TAPC_ADDR_SCALING)
      |=> (reg_rdata == {21'h00_0000, $past(ambient_correction_scaling)})
  ) else $error("scaling read wrong");

  knee_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `TAPC_ADDR_KNEE_LOW)
      |=> (reg_rdata == {3'h0, $past(unwrapped_phase_output_en), $past(ambient_knee_second),
                         $past(ambient_knee_first)})
  ) else $error("knee read wrong");

  select_write_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `TAPC_ADDR_DRIVE)
      |=> ({ch2_ambient_input_select, ch1_ambient_input_select, ch0_ambient_input_select} == $past(reg_wdata[17:12]))
  ) else $error("input selects not stored");

  phase_normal_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !unwrapped_phase_output_en
      |=> (phase_out == $past(phase_normal))
  ) else $error("phase output is not the normal phase");

  amb_two_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (chan_sel == TAPC_CH2)
      |=> (ambient_input_sel == $past(ch2_ambient_input_select))
  ) else $error("ambient input does not follow channel two select");

  amb_zero_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (chan_sel == TAPC_CH0)
      |=> (ambient_input_sel == $past(ch0_ambient_input_select))
  ) else $error("ambient input does not follow channel zero select");

  drive_off_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !illum_on
      |=> (emitter_drive_en == 3'h0)
  ) else $error("emitter driven while dark");

endmodule

// ---- hw/tapc_steer.sv ----
// Per-channel steering: phase output choice, ambient ADC input and emitter drive routing.
// Assumes channel, phase and enable inputs are synchronous to clk.
`include "tapc_params.svh"

module tapc_steer
  import tapc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire tapc_chan_t  chan_sel,
  input  wire logic        illum_on,
  input  wire logic [15:0] phase_normal,
  input  wire logic [15:0] phase_unwrapped,
  input  wire logic        unwrap_en,
  input  wire logic [1:0]  amb_sel_ch0,
  input  wire logic [1:0]  amb_sel_ch1,
  input  wire logic [1:0]  amb_sel_ch2,
  input  wire logic        reroute_ch1,
  input  wire logic        reroute_ch2,
  output logic      [15:0] phase_out,
  output logic      [1:0]  ambient_input_sel,
  output logic      [2:0]  emitter_drive_en
);

  tapc_steer_t st_r;
  tapc_steer_t st_nxt;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = unwrap_en ? phase_unwrapped : phase_normal;
    st_nxt.amb_sel = 2'h0;
    st_nxt.drive_en = `TAPC_DRIVE_NONE;
    unique case (chan_sel)
      TAPC_CH0: begin
        st_nxt.amb_sel = amb_sel_ch0;
        st_nxt.drive_en = `TAPC_DRIVE_CH0;
      end
      TAPC_CH1: begin
        st_nxt.amb_sel = amb_sel_ch1;
        st_nxt.drive_en = reroute_ch1 ? `TAPC_DRIVE_CH0 : `TAPC_DRIVE_CH1;
      end
      TAPC_CH2: begin
        st_nxt.amb_sel = amb_sel_ch2;
        st_nxt.drive_en = reroute_ch2 ? `TAPC_DRIVE_CH0 : `TAPC_DRIVE_CH2;
      end
      TAPC_CH_NONE: begin
        st_nxt.drive_en = `TAPC_DRIVE_NONE;
      end
    endcase
    if (!illum_on) begin
      st_nxt.drive_en = `TAPC_DRIVE_NONE;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign phase_out         = st_r.phase;
  assign ambient_input_sel = st_r.amb_sel;
  assign emitter_drive_en  = st_r.drive_en;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  phase_select_a: assert property (
    @(posedge clk) disable iff (!resetn)
    unwrap_en |=> (phase_out == $past(phase_unwrapped))
  ) else $error("phase output is not the unwrapped phase");

  amb_select_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (chan_sel == TAPC_CH1) |=> (ambient_input_sel == $past(amb_sel_ch1))
  ) else $error("ambient input does not follow channel one select");

  reroute_two_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (chan_sel == TAPC_CH2) && illum_on && reroute_ch2 |=> (emitter_drive_en == `TAPC_DRIVE_CH0)
  ) else $error("channel two current not steered to emitter zero");

  reroute_one_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (chan_sel == TAPC_CH1) && illum_on |=> (emitter_drive_en == ($past(reroute_ch1) ? 3'h1 : 3'h2))
  ) else $error("channel one current routed wrongly");

endmodule

// ---- shared/tapc_params.svh ----
// Offsets, field positions, masks and reset values of the ambient phase correction bank.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef TAPC_PARAMS_SVH
`define TAPC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TAPC_ADDR_QUARTIC   8'hb2
`define TAPC_ADDR_SEGCOEFF  8'hb4
`define TAPC_ADDR_SCALING   8'hb5
`define TAPC_ADDR_KNEE_LOW  8'hb8
`define TAPC_ADDR_DRIVE     8'hb9

// ----------------------------------------------------------------------------
// Writable bit masks (reserved bits are zero)
// ----------------------------------------------------------------------------
`define TAPC_MASK_QUARTIC   24'h00_ffff
`define TAPC_MASK_SEGCOEFF  24'hff_ffff
`define TAPC_MASK_SCALING   24'h00_0007
`define TAPC_MASK_KNEE_LOW  24'h1f_ffff
`define TAPC_MASK_DRIVE     24'hff_ffff

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TAPC_RST_QUARTIC    24'h00_0000
`define TAPC_RST_SEGCOEFF   24'h00_0000
`define TAPC_RST_SCALING    24'h00_0000
`define TAPC_RST_KNEE_LOW   24'h07_fdff
`define TAPC_RST_DRIVE      24'h00_01ff

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TAPC_QUARTIC_MSB    15
`define TAPC_QUARTIC_LSB    0
`define TAPC_SEG3_MSB       23
`define TAPC_SEG3_LSB       16
`define TAPC_SEG2_MSB       15
`define TAPC_SEG2_LSB       8
`define TAPC_SEG1_MSB       7
`define TAPC_SEG1_LSB       0
`define TAPC_SCALING_MSB    2
`define TAPC_SCALING_LSB    0
`define TAPC_UNWRAP_BIT     20
`define TAPC_KNEE2_MSB      19
`define TAPC_KNEE2_LSB      10
`define TAPC_KNEE1_MSB      9
`define TAPC_KNEE1_LSB      0
`define TAPC_SCALE_H_MSB    23
`define TAPC_SCALE_H_LSB    21
`define TAPC_SCALE_L_MSB    20
`define TAPC_SCALE_L_LSB    18
`define TAPC_AMB2_MSB       17
`define TAPC_AMB2_LSB       16
`define TAPC_AMB1_MSB       15
`define TAPC_AMB1_LSB       14
`define TAPC_AMB0_MSB       13
`define TAPC_AMB0_LSB       12
`define TAPC_RR2_BIT        11
`define TAPC_RR1_BIT        10
`define TAPC_KNEE3_MSB      9
`define TAPC_KNEE3_LSB      0

// Highest legal current scale code
`define TAPC_SCALE_MAX      3'h3

// Emitter drive patterns: one-hot for a channel, zero for none
`define TAPC_DRIVE_NONE     3'h0
`define TAPC_DRIVE_CH0      3'h1
`define TAPC_DRIVE_CH1      3'h2
`define TAPC_DRIVE_CH2      3'h4

`endif

// ---- shared/tapc_pkg.sv ----
// Types shared by the ambient phase correction register bank and its steering logic.
// Assumes tapc_params.svh is on the include path.
`include "tapc_params.svh"

package tapc_pkg;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef logic [23:0] tapc_word_t;

  // Active transmit channel code
  typedef enum logic [1:0] {
    TAPC_CH0     = 2'h0,
    TAPC_CH1     = 2'h1,
    TAPC_CH2     = 2'h2,
    TAPC_CH_NONE = 2'h3
  } tapc_chan_t;

  // Register bank state
  typedef struct packed {
    tapc_word_t  quartic;
    tapc_word_t  segcoeff;
    tapc_word_t  scaling;
    tapc_word_t  knee_low;
    tapc_word_t  drive;
    tapc_word_t  rdata;
    logic        rvalid;
    logic        scale_bad;
  } tapc_regs_t;

  // Steering state
  typedef struct packed {
    logic [15:0] phase;
    logic [1:0]  amb_sel;
    logic [2:0]  drive_en;
  } tapc_steer_t;

endpackage
